// *** rtl/ssb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module ssb_top (
   // system clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // serial link pins
   input  wire logic        SCLK,
   input  wire logic        HW_RST_N,
   input  wire logic        CS_N,
   input  wire logic        SDI,
   output logic             SDO,
   output logic             SDO_OE,
   output logic             BUSY_N_O,
   output logic             BUSY_N_OE,
   // core side
   output logic             CMD_VALID,
   output logic             CMD_WRITE,
   output logic [6:0]       CMD_ADDR,
   output logic [1:0]       CMD_CHAN,
   output logic [15:0]      CMD_DATA,
   output logic             DEV_BUSY,
   input  wire logic [15:0] RD_DATA,
   output logic             SER_TRI_EN
);
   import ssb_pkg::*;

   typedef struct packed {
      logic        rstq;
      logic        sel;
      logic [1:0]  gap;
      logic        ok_gap;
      logic [5:0]  nbit;
      logic [25:0] rx;
      logic [25:0] tx;
      logic [25:0] cmd;
      logic        tgl;
      logic        rdreq;
      logic [9:0]  echo;
      logic        tri_en;
      logic        busy;
      logic [9:0]  bcnt;
      logic [15:0] rd1;
      logic [15:0] rd2;
      logic        oe;
   } ssb_lk_t;

   // hardware reset leaves a pending busy sequence and a driven output
   localparam ssb_lk_t LK_RST = '{rstq: 1'b1, oe: 1'b1,
                                  gap: MIN_DESELECT_EDGES, default: '0};

   ssb_cmd_if sif ();

   ssb_lk_t    q;
   ssb_lk_t    next_q;
   logic       rel_ok;
   logic       swrst;
   logic       rst_go;
   logic       is_wr;
   logic [6:0] addr;

   // release decode, seen on the first edge with chip select high
   always_comb begin
      is_wr  = q.rx[RW_POS];
      addr   = q.rx[ADDR_HI:ADDR_LO];
      rel_ok = CS_N && q.sel && q.ok_gap && (q.nbit == WORD_BITS);
      swrst  = rel_ok && !q.rdreq && is_wr && (addr == SWRST_ADDR);
      rst_go = q.rstq || swrst;
   end

   // serial-clock side next state
   always_comb begin
      next_q     = q;
      next_q.rd1 = sif.rd_data;
      next_q.rd2 = q.rd1;
      next_q.oe  = q.tri_en ? !CS_N : 1'b1;
      if (q.busy) begin
         if (q.bcnt == '0) begin
            next_q.busy = 1'b0;
         end else begin
            next_q.bcnt = q.bcnt - 10'h001;
         end
      end
      if (!CS_N) begin
         // frames opened during busy are dropped
         if (!q.sel) begin
            next_q.ok_gap = (q.gap == MIN_DESELECT_EDGES) && !q.busy;
            next_q.nbit   = 6'h01;
         end else if (q.nbit != 6'h3F) begin
            next_q.nbit = q.nbit + 6'h01;
         end
         next_q.sel = 1'b1;
         next_q.gap = '0;
         next_q.rx  = {q.rx[24:0], SDI};
         next_q.tx  = {q.tx[24:0], 1'b0};
      end else begin
         next_q.sel = 1'b0;
         if (q.gap != MIN_DESELECT_EDGES) begin
            next_q.gap = q.gap + 2'h1;
         end
         // echo with write bit low, then data
         next_q.tx = q.rdreq ? {q.echo, q.rd2} : '0;
      end
      // busy on first edge after valid release
      if (rel_ok) begin
         next_q.busy = 1'b1;
         next_q.bcnt = BUSY_HOLD_SPAN - 10'h001;
         if (q.rdreq) begin
            // readout frame: input ignored
            next_q.rdreq = 1'b0;
         end else begin
            next_q.cmd   = q.rx;
            next_q.tgl   = !q.tgl;
            next_q.rdreq = !is_wr;
            next_q.echo  = {1'b0, q.rx[ADDR_HI:CHAN_LO]};
            if (is_wr && (addr == CTRL_ADDR)) begin
               next_q.tri_en = q.rx[TRI_BIT];
            end
         end
      end
      if (rst_go) begin
         next_q.rstq   = 1'b0;
         next_q.busy   = 1'b1;
         next_q.bcnt   = RESET_BUSY_SPAN - 10'h001;
         next_q.tri_en = 1'b0;
         next_q.rdreq  = 1'b0;
      end
   end

   // pin reset acts at once; serial clock may be stopped
   always_ff @(posedge SCLK or negedge HW_RST_N) begin
      if (!HW_RST_N) begin
         q <= LK_RST;
      end else begin
         q <= next_q;
      end
   end

   assign sif.tgl  = q.tgl;
   assign sif.cmd  = q.cmd;
   assign sif.busy = q.busy;

   assign SDO        = q.tx[25];
   assign SDO_OE     = q.oe;
   // open drain: pulls low while busy
   assign BUSY_N_O   = 1'b0;
   assign BUSY_N_OE  = q.busy;
   assign SER_TRI_EN = q.tri_en;

   ssb_cmd_sync u_sync (
      .clk       (CLK),
      .rst       (RST),
      .sif       (sif.core),
      .cmd_valid (CMD_VALID),
      .cmd_write (CMD_WRITE),
      .cmd_addr  (CMD_ADDR),
      .cmd_chan  (CMD_CHAN),
      .cmd_data  (CMD_DATA),
      .dev_busy  (DEV_BUSY),
      .rd_data   (RD_DATA)
   );

   // checks on the serial-clock side
   AST_BUSY_ASSERT: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      rel_ok |=> BUSY_N_OE)
      else $error("busy missing after valid release");

   AST_BUSY_SHORT: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      (rel_ok && !swrst) |=> BUSY_N_OE [*3] ##[1:19] !BUSY_N_OE)
      else $error("ordinary busy span out of range");

   AST_BUSY_RESET: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      rst_go |=> BUSY_N_OE && (q.bcnt == RESET_BUSY_SPAN - 10'h001))
      else $error("reset busy sequence not loaded");

   AST_BUSY_COUNT: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      (q.busy && q.bcnt != '0 && !rel_ok && !rst_go)
      |=> q.busy && (q.bcnt == $past(q.bcnt) - 10'h001))
      else $error("busy counter did not step");

   AST_BUSY_RELEASE: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      (q.busy && (q.bcnt != '0)) |=> BUSY_N_OE)
      else $error("busy released before count end");

   AST_SDI_SAMPLE: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      !CS_N |=> q.rx[0] == $past(SDI))
      else $error("serial input not sampled");

   AST_SDO_SHIFT: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      (!CS_N && q.sel) |=> SDO == $past(q.tx[24]))
      else $error("serial output did not advance");

   AST_SDO_TRI: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      (q.tri_en && !rst_go) |=> SDO_OE == !$past(CS_N))
      else $error("output enable does not follow select");

   AST_SDO_DRIVEN: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      !q.tri_en |=> SDO_OE)
      else $error("output released with tristating off");

   AST_ECHO: assert property (
      @(posedge SCLK) disable iff (!HW_RST_N)
      (rel_ok && !q.rdreq && !is_wr && !swrst) |=> q.rdreq
      && (q.echo == {1'b0, $past(q.rx[ADDR_HI:CHAN_LO])}))
      else $error("read request echo wrong");

   COV_WRITE: cover property (@(posedge SCLK) disable iff (!HW_RST_N)
      rel_ok && is_wr && !q.rdreq);
   COV_READREQ: cover property (@(posedge SCLK) disable iff (!HW_RST_N)
      rel_ok && !is_wr && !q.rdreq);
   COV_READOUT: cover property (@(posedge SCLK) disable iff (!HW_RST_N)
      rel_ok && q.rdreq);
   COV_SWRST: cover property (@(posedge SCLK) disable iff (!HW_RST_N)
      swrst);
endmodule : ssb_top
`default_nettype wire

// *** rtl/ssb_pkg.sv ***
// Summary of operation
// - Busy asserts on the first rising serial-clock edge after a valid release or after hardware reset release.
// - After an ordinary transfer busy is released 3 to 21 cycles after that first edge.
// - After hardware reset or a software reset command busy holds for at least 744 cycles.
// - Busy is released on a serial-clock edge or at once by hardware reset, so the host keeps the clock running until then.
// - Serial input data is sampled on rising serial-clock edges.
// - Each serial output bit is launched from a rising serial-clock edge.
// - With tristating on, serial output is driven while selected and released to high impedance otherwise.
// - Control bit 1 at address 0x12 turns tristating on when set and keeps the output driven when clear.
// - A readout after a read request echoes the write bit low and 9 address and channel bits, then 16 data bits.
`default_nettype none
package ssb_pkg;
   // word layout, most significant bit first on the wire
   localparam logic [5:0] MIN_EDGES_PER_OP = 6'h1D;
   localparam logic [1:0] MIN_DESELECT_EDGES = 2'h3;
   localparam logic [5:0] WORD_BITS = 6'h1A;
   localparam int         RW_POS    = 25;
   localparam int         ADDR_HI   = 24;
   localparam int         ADDR_LO   = 18;
   localparam int         CHAN_LO   = 16;
   localparam int         DATA_HI   = 15;
   localparam int         TRI_BIT   = 1;
   // command addresses
   localparam logic [6:0] CTRL_ADDR  = 7'h12;
   localparam logic [6:0] SWRST_ADDR = 7'h7F;
   // busy spans in serial-clock cycles
   localparam logic [9:0] BUSY_HOLD_SPAN  = 10'h004;
   localparam logic [9:0] RESET_BUSY_SPAN = 10'h2E8;
endpackage : ssb_pkg
`default_nettype wire

// *** rtl/ssb_cmd_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// crossing bundle between the serial-clock side and the core side
interface ssb_cmd_if;
   logic        tgl;
   logic [25:0] cmd;
   logic        busy;
   logic [15:0] rd_data;
   modport lk   (output tgl, output cmd, output busy, input rd_data);
   modport core (input tgl, input cmd, input busy, output rd_data);
endinterface : ssb_cmd_if
`default_nettype wire

// *** rtl/ssb_cmd_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module ssb_cmd_sync (
   // system clock
   input  wire logic        clk,
   input  wire logic        rst,
   // crossing bundle
   ssb_cmd_if.core          sif,
   // core side
   output logic             cmd_valid,
   output logic             cmd_write,
   output logic [6:0]       cmd_addr,
   output logic [1:0]       cmd_chan,
   output logic [15:0]      cmd_data,
   output logic             dev_busy,
   input  wire logic [15:0] rd_data
);
   import ssb_pkg::*;

   typedef struct packed {
      logic [2:0]  ts;
      logic [1:0]  bs;
      logic        vld;
      logic [25:0] word;
      logic [15:0] rdh;
   } ssb_ct_t;

   ssb_ct_t q;
   ssb_ct_t next_q;

   // toggle sync; ts[0] feeds only ts[1]
   always_comb begin
      next_q       = q;
      next_q.ts    = {q.ts[1:0], sif.tgl};
      next_q.bs    = {q.bs[0], sif.busy};
      next_q.vld   = q.ts[2] ^ q.ts[1];
      // word is stable long before the toggle lands
      if (q.ts[2] ^ q.ts[1]) begin
         next_q.word = sif.cmd;
      end
      next_q.rdh   = rd_data;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign sif.rd_data = q.rdh;
   assign cmd_valid   = q.vld;
   assign cmd_write   = q.word[RW_POS];
   assign cmd_addr    = q.word[ADDR_HI:ADDR_LO];
   assign cmd_chan    = q.word[ADDR_LO-1:CHAN_LO];
   assign cmd_data    = q.word[DATA_HI:0];
   assign dev_busy    = q.bs[1];

   AST_CMD_PULSE: assert property (@(posedge clk) disable iff (rst)
      cmd_valid |=> !cmd_valid)
      else $error("command strobe longer than one cycle");
endmodule : ssb_cmd_sync
`default_nettype wire

// *** verification/ssb_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// host side of the serial link; clock runs only in frames and busy
module ssb_host (
   // link outputs
   output logic      sclk,
   output logic      hw_rst_n,
   output logic      cs_n,
   output logic      sdi,
   // device answers
   input  wire logic sdo,
   input  wire logic sdo_oe,
   input  wire logic busy_n
);
   logic        run;
   logic        at0;
   logic        oe_mid;
   logic [25:0] so;
   int          nbusy;

   // parked low when idle, so stray edges never reach the device
   initial begin
      {sclk, run, at0, oe_mid, sdi} = 5'h00;
      so    = '0;
      nbusy = 0;
      // reset pin idles high so the first reset is a real falling edge
      {cs_n, hw_rst_n} = 2'h3;
      #3;
      forever begin
         #40;
         if (run || sclk) sclk = ~sclk;
      end
   end

   // clock kept running until busy ends
   task automatic busy_wait();
      nbusy = 0;
      @(posedge sclk);
      #1 at0 = (busy_n === 1'b0);
      while (busy_n === 1'b0 && nbusy < 2000) begin
         @(posedge sclk);
         #1 nbusy++;
      end
      @(negedge sclk);
      run = 1'b0;
   endtask : busy_wait

   // hardware reset, then wait out the reset busy
   task automatic hw_reset();
      hw_rst_n = 1'b0;
      #20 hw_rst_n = 1'b1;
      run = 1'b1;
      busy_wait();
   endtask : hw_reset

   // gap, then word MSB first, read back sampled
   task automatic frame(input logic [25:0] w, input int nb, gap);
      so = '0;
      oe_mid = 1'b0;
      run = 1'b1;
      repeat (gap) @(negedge sclk);
      for (int i = 0; i < nb; i++) begin
         so = {so[24:0], sdo};
         if (i == 13) oe_mid = sdo_oe;
         cs_n = 1'b0;
         sdi = (i < 26) ? w[25 - i] : 1'b0;
         @(negedge sclk);
      end
      cs_n = 1'b1;
      sdi = ~sdi;
      busy_wait();
   endtask : frame
endmodule : ssb_host
`default_nettype wire

// *** verification/ssb_top_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module ssb_top_bench;
   import ssb_pkg::*;
   logic        clk;
   logic        rst;
   logic [15:0] rd_data;
   wire         sclk, hw_rst_n, cs_n, sdi, sdo, sdo_oe, sdo_w;
   wire         busy_n_o, busy_n_oe, busy_n, cmd_valid, cmd_write;
   wire  [6:0]  cmd_addr;
   wire  [1:0]  cmd_chan;
   wire  [15:0] cmd_data;
   wire         dev_busy, ser_tri_en;
   logic [25:0] cmd_seen;
   int          n_cmd = 0;
   int          n_dbusy = 0;
   int          cyc = 0;
   int          n_fail = 0;
   int          n_compared = 0;

   // pin levels: sdo floats when released, busy has a pull-up
   assign sdo_w = sdo_oe ? sdo : 1'bz;
   assign busy_n = busy_n_oe ? busy_n_o : 1'b1;

   ssb_top i_dut (
      .CLK(clk), .RST(rst), .SCLK(sclk), .HW_RST_N(hw_rst_n),
      .CS_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
      .BUSY_N_O(busy_n_o), .BUSY_N_OE(busy_n_oe),
      .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
      .CMD_ADDR(cmd_addr), .CMD_CHAN(cmd_chan), .CMD_DATA(cmd_data),
      .DEV_BUSY(dev_busy), .RD_DATA(rd_data), .SER_TRI_EN(ser_tri_en)
   );

   ssb_host i_host (
      .sclk(sclk), .hw_rst_n(hw_rst_n), .cs_n(cs_n), .sdi(sdi),
      .sdo(sdo_w), .sdo_oe(sdo_oe), .busy_n(busy_n)
   );

   // system clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // command capture and hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (dev_busy === 1'b1) n_dbusy <= n_dbusy + 1;
      if (cmd_valid === 1'b1) begin
         n_cmd <= n_cmd + 1;
         cmd_seen <= {cmd_write, cmd_addr, cmd_chan, cmd_data};
      end
      if (cyc == 60000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic check(input logic [25:0] seen, exp, input string m);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   // one frame, then busy, span and command checks
   task automatic op(input logic [25:0] w, input int nb, gap, ec, lo, hi);
      int c0;
      int d0;
      c0 = n_cmd;
      d0 = n_dbusy;
      i_host.frame(w, nb, gap);
      repeat (12) @(negedge clk);
      check(26'(i_host.at0), 26'(hi > 0), "busy start");
      check(26'(n_dbusy > d0), 26'(hi > 0), "core busy seen");
      check(26'(dev_busy), 26'h0, "core busy idle");
      check(26'(i_host.nbusy >= lo && i_host.nbusy <= hi), 26'h1,
            "busy span");
      if (ec >= 0) check(26'(n_cmd - c0), 26'(ec), "cmd count");
      if (ec == 1) check(cmd_seen, w, "cmd word");
   endtask : op

   // main sequence
   initial begin
      logic [6:0]  a;
      logic [1:0]  ch;
      logic [25:0] w;
      void'($urandom(32'h9941));
      rst = 1'b1;
      rd_data = 16'h0000;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      i_host.hw_reset();
      check(26'(i_host.at0), 26'h1, "reset busy start");
      check(26'(i_host.nbusy >= 744), 26'h1, "reset span");
      check(26'(n_dbusy > 0), 26'h1, "core busy on reset");
      // random writes, special addresses steered away
      for (int k = 0; k < 6; k++) begin
         a = 7'($urandom);
         if (a == CTRL_ADDR || a == SWRST_ADDR) a = 7'h20;
         w = {1'b1, a, 18'($urandom)};
         op(w, 26, 3 + k, 1, 3, 21);
      end
      op({1'b1, CTRL_ADDR, 18'h00002}, 26, 3, 1, 3, 21);
      check(26'(ser_tri_en), 26'h1, "tri bit set");
      check(26'(sdo_oe), 26'h0, "idle sdo released");
      op(w, 26, 3, 1, 3, 21);
      check(26'(i_host.oe_mid), 26'h1, "selected sdo on");
      op({1'b1, CTRL_ADDR, 18'h0FFFD}, 26, 3, 1, 3, 21);
      check(26'(sdo_oe), 26'h1, "sdo kept on");
      // wrong bit counts and a short gap are dropped
      op(w, 25, 3, 0, 0, 0);
      op(w, 26, 0, 0, 0, 0);
      op(w, 27, 3, 0, 0, 0);
      // read request, then readout of echo and data
      a = 7'h31;
      ch = 2'($urandom);
      @(negedge clk) rd_data = 16'($urandom);
      op({1'b0, a, ch, 16'h0000}, 26, 3, 1, 3, 21);
      op(26'($urandom), 26, 3, 0, 3, 21);
      check(i_host.so, {1'b0, a, ch, rd_data}, "readout");
      // software reset drops the tristate bit
      op({1'b1, CTRL_ADDR, 18'h00002}, 26, 3, 1, 3, 21);
      op({1'b1, SWRST_ADDR, 18'h00000}, 26, 3, -1, 744, 2000);
      check(26'(ser_tri_en), 26'h0, "soft reset");
      report_and_stop();
   end
endmodule : ssb_top_bench
`default_nettype wire
